// File: wdc_watchdog.sv
// Functional notes
// RL1 - counter advances only on interval timer tick pulses, never the raw clock
// RL2 - interval timer tick input sets the count rate of the watchdog
// RL3 - seven bit counter paired with software writable compare field
// RL4 - match of counter with compare bits six to zero sets request flag
// RL5 - enable bit chooses interrupt request or cpu reset on a match
// RL6 - enable zero gives plain interval timer, one gives reset watchdog
// RL7 - with enable one, reset blocked only while disable code holds a5, else armed
// RL8 - after reset disable code reads 00 and enable bit reads one
// RL9 - clear bit zeroes counter, self clears after one cycle, counting resumes
// RL10 - without malfunction detection matches give periodic interrupts
// RL11 - software must clear counter periodically before a match occurs
// RL12 - counter increments by one per tick and wraps 127 to 0
module wdc_watchdog
    import wdc_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // register port
    input wire wdc_req_t bus_req,
    output logic [7:0] bus_rdata,
    // time base from interval timer
    input wire logic bit_tick,
    // events
    input wire logic irq_ack,
    output logic irq_flag,
    output logic cpu_reset_req
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [6:0] cnt_q, cnt_d;
    logic [6:0] cmp_q, cmp_d;
    logic clr_q, clr_d;
    logic [7:0] code_q, code_d;
    logic en_q, en_d;
    logic irq_q, irq_d;
    logic rst_q, rst_d;
    logic [7:0] rdata_q, rdata_d;
    logic match;
    logic armed;
    logic wr_cmp;
    logic wr_code;
    logic wr_ctrl;
    logic clr_wr;
    logic fire;
    logic [7:0] ctrl_view;
    logic [7:0] cmp_view;

    // ----------------------------------------------------------------
    // decode and compare
    // ----------------------------------------------------------------
    assign wr_cmp = bus_req.wr && (bus_req.addr == WDC_ADDR_COMPARE_CLEAR);
    assign wr_code = bus_req.wr && (bus_req.addr == WDC_ADDR_DISABLE_CODE);
    assign wr_ctrl = bus_req.wr && (bus_req.addr == WDC_ADDR_CONTROL);
    assign clr_wr = wr_cmp && bus_req.wdata[WDC_CLEAR_BIT];
    assign match = (cnt_q == cmp_q); // RL4
    // magic value disables only the reset path, the flag still works
    assign armed = en_q && (code_q != WDC_DISABLE_MAGIC); // RL7
    // a match counts only on a tick that the clear cycle does not swallow
    assign fire = bit_tick && match && !clr_q; // RL4

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // the counter never sees the raw clock rate, only the interval tick
    always_comb begin
        cnt_d = cnt_q;
        if (clr_q) begin
            cnt_d = WDC_CNT_ZERO; // RL9
        end else if (bit_tick) begin
            cnt_d = cnt_q + WDC_CNT_ONE; // RL1 RL2 RL12
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cnt_q <= WDC_CNT_ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // ----------------------------------------------------------------
    // compare field and clear bit
    // ----------------------------------------------------------------
    always_comb begin
        cmp_d = cmp_q;
        clr_d = 1'b0; // RL9
        if (wr_cmp) begin
            cmp_d = bus_req.wdata[WDC_CLEAR_BIT-1:0]; // RL3
            clr_d = bus_req.wdata[WDC_CLEAR_BIT];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            cmp_q <= WDC_RST_COMPARE[WDC_CLEAR_BIT-1:0];
            clr_q <= WDC_RST_COMPARE[WDC_CLEAR_BIT];
        end else begin
            cmp_q <= cmp_d;
            clr_q <= clr_d;
        end
    end

    // ----------------------------------------------------------------
    // disable code
    // ----------------------------------------------------------------
    // with the enable bit set, any value but the magic one keeps the reset path live
    always_comb begin
        code_d = code_q;
        if (wr_code) begin
            code_d = bus_req.wdata; // RL7
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            code_q <= WDC_RST_DISABLE_CODE; // RL8
        end else begin
            code_q <= code_d;
        end
    end

    // ----------------------------------------------------------------
    // enable bit
    // ----------------------------------------------------------------
    // armed from reset, so a hang before setup still recovers
    always_comb begin
        en_d = en_q;
        if (wr_ctrl) begin
            en_d = bus_req.wdata[WDC_ENABLE_BIT]; // RL6
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            en_q <= WDC_RST_ENABLE; // RL8
        end else begin
            en_q <= en_d;
        end
    end

    // ----------------------------------------------------------------
    // request flag and reset pulse
    // ----------------------------------------------------------------
    always_comb begin
        irq_d = irq_q;
        rst_d = 1'b0;
        if (irq_ack) begin
            irq_d = 1'b0;
        end
        // a tick landing on a match beats the acknowledge
        if (fire) begin
            if (armed) begin
                rst_d = 1'b1; // RL5 RL6
            end else begin
                irq_d = 1'b1; // RL4 RL6 RL10
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            irq_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
            rst_q <= rst_d;
        end
    end

    assign irq_flag = irq_q;
    // a single cycle pulse, the cpu side must latch it
    assign cpu_reset_req = rst_q;

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    assign cmp_view = {clr_q, cmp_q};
    assign ctrl_view = 8'(en_q) << WDC_ENABLE_BIT;
    // data is zero outside the cycle after a read, so a stray sample is harmless
    always_comb begin
        rdata_d = 8'h00;
        if (bus_req.rd) begin
            case (bus_req.addr)
                WDC_ADDR_COMPARE_CLEAR: rdata_d = cmp_view;
                WDC_ADDR_DISABLE_CODE: rdata_d = code_q;
                WDC_ADDR_CONTROL: rdata_d = ctrl_view; // RL6
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign bus_rdata = rdata_q;

    // ----------------------------------------------------------------
    // counter checks
    // ----------------------------------------------------------------
    AST_CLEAR_ZEROES: assert property (@(posedge core_clk) disable iff (!rstn) // RL9
        clr_q
        |=> cnt_q == WDC_CNT_ZERO)
        else $error("clear bit did not zero counter");

    AST_CLEAR_SELF: assert property (@(posedge core_clk) disable iff (!rstn) // RL9
        clr_wr
        |=> clr_q)
        else $error("clear bit not taken");

    AST_CLEAR_DROP: assert property (@(posedge core_clk) disable iff (!rstn) // RL9
        clr_q && !clr_wr
        |=> !clr_q)
        else $error("clear bit not self clearing");

    AST_TICK_INC: assert property (@(posedge core_clk) disable iff (!rstn) // RL12
        bit_tick && !clr_q
        |=> cnt_q == $past(cnt_q) + WDC_CNT_ONE)
        else $error("counter did not step by one");

    AST_HOLD: assert property (@(posedge core_clk) disable iff (!rstn) // RL1
        !bit_tick && !clr_q
        |=> $stable(cnt_q))
        else $error("counter moved without tick");

    AST_WRAP: assert property (@(posedge core_clk) disable iff (!rstn) // RL12
        bit_tick && !clr_q && (&cnt_q)
        |=> cnt_q == WDC_CNT_ZERO)
        else $error("counter did not wrap");

    AST_RATE: assert property (@(posedge core_clk) disable iff (!rstn) // RL2
        $changed(cnt_q)
        |-> $past(bit_tick) || $past(clr_q))
        else $error("counter moved off the time base");

    // ----------------------------------------------------------------
    // register checks
    // ----------------------------------------------------------------
    AST_CMP_WRITE: assert property (@(posedge core_clk) disable iff (!rstn) // RL3
        wr_cmp
        |=> cmp_q == $past(bus_req.wdata[WDC_CLEAR_BIT-1:0]))
        else $error("compare field not written");

    AST_CMP_KEEP: assert property (@(posedge core_clk) disable iff (!rstn) // RL3
        !wr_cmp
        |=> $stable(cmp_q))
        else $error("compare field changed without write");

    AST_CODE_WRITE: assert property (@(posedge core_clk) disable iff (!rstn) // RL7
        wr_code
        |=> code_q == $past(bus_req.wdata))
        else $error("disable code not written");

    AST_EN_WRITE: assert property (@(posedge core_clk) disable iff (!rstn) // RL6
        wr_ctrl
        |=> en_q == $past(bus_req.wdata[WDC_ENABLE_BIT]))
        else $error("enable bit not written");

    AST_RESET_VAL: assert property (@(posedge core_clk) // RL8
        !rstn
        |=> en_q && code_q == WDC_RST_DISABLE_CODE)
        else $error("wrong reset defaults");

    AST_RESET_CMP: assert property (@(posedge core_clk) // RL3
        !rstn
        |=> cmp_q == WDC_RST_COMPARE[WDC_CLEAR_BIT-1:0])
        else $error("wrong compare reset value");

    // ----------------------------------------------------------------
    // event checks
    // ----------------------------------------------------------------
    AST_IRQ_SET: assert property (@(posedge core_clk) disable iff (!rstn) // RL4
        fire && !armed
        |=> irq_flag)
        else $error("match did not raise flag");

    AST_RST_SET: assert property (@(posedge core_clk) disable iff (!rstn) // RL5
        fire && armed
        |=> cpu_reset_req)
        else $error("armed match did not raise reset");

    AST_RST_PULSE: assert property (@(posedge core_clk) disable iff (!rstn) // RL5
        cpu_reset_req
        |=> !cpu_reset_req)
        else $error("reset request longer than one cycle");

    AST_RST_CAUSE: assert property (@(posedge core_clk) disable iff (!rstn) // RL5
        cpu_reset_req
        |-> $past(fire) && $past(armed))
        else $error("reset request without armed match");

    AST_MAGIC: assert property (@(posedge core_clk) disable iff (!rstn) // RL7
        code_q == WDC_DISABLE_MAGIC
        |=> !cpu_reset_req)
        else $error("reset while disable code held");

    AST_TIMER_MODE: assert property (@(posedge core_clk) disable iff (!rstn) // RL6
        !en_q
        |=> !cpu_reset_req)
        else $error("reset in plain timer mode");

    AST_IRQ_HOLD: assert property (@(posedge core_clk) disable iff (!rstn) // RL10
        irq_flag && !irq_ack
        |=> irq_flag)
        else $error("flag dropped without acknowledge");

    AST_IRQ_CLEAR: assert property (@(posedge core_clk) disable iff (!rstn) // RL4
        irq_ack && !fire
        |=> !irq_flag)
        else $error("acknowledge did not clear flag");

    AST_ARMED_NO_FLAG: assert property (@(posedge core_clk) disable iff (!rstn) // RL5
        fire && armed && !irq_flag
        |=> !irq_flag)
        else $error("armed match raised the flag");

    // ----------------------------------------------------------------
    // read checks
    // ----------------------------------------------------------------
    AST_RD_IDLE: assert property (@(posedge core_clk) disable iff (!rstn) // RL3
        !bus_req.rd
        |=> bus_rdata == 8'h00)
        else $error("read data outside read cycle");

    AST_RD_CODE: assert property (@(posedge core_clk) disable iff (!rstn) // RL7
        bus_req.rd && bus_req.addr == WDC_ADDR_DISABLE_CODE
        |=> bus_rdata == $past(code_q))
        else $error("disable code read back wrong");
endmodule

// File: wdc_pkg.sv
package wdc_pkg;
    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    localparam logic [7:0] WDC_ADDR_COMPARE_CLEAR = 8'hf4;
    localparam logic [7:0] WDC_ADDR_DISABLE_CODE = 8'hf6;
    localparam logic [7:0] WDC_ADDR_CONTROL = 8'hf2;
    localparam logic [7:0] WDC_RST_COMPARE = 8'h7f;
    localparam logic [7:0] WDC_RST_DISABLE_CODE = 8'h00;
    localparam logic [7:0] WDC_DISABLE_MAGIC = 8'ha5;
    localparam logic WDC_RST_ENABLE = 1'b1;
    localparam int WDC_CLEAR_BIT = 7;
    localparam int WDC_ENABLE_BIT = 4;
    localparam logic [6:0] WDC_CNT_ZERO = 7'h00;
    localparam logic [6:0] WDC_CNT_ONE = 7'h01;

    // --------------------------------------------------------------
    // register bus request
    // --------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } wdc_req_t;
endpackage

// File: wdc_cpu_model.sv
module wdc_cpu_model (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic irq_flag,
    input wire logic cpu_reset_req,
    output logic irq_ack,
    output int irq_seen,
    output int rst_seen
);
    timeunit 1ns;
    timeprecision 1ps;
    // acks one cycle after the flag shows, so each request is counted once
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            irq_ack <= 1'b0;
            irq_seen <= 0;
            rst_seen <= 0;
        end else begin
            irq_ack <= irq_flag & ~irq_ack;
            if (irq_flag & ~irq_ack) irq_seen <= irq_seen + 1;
            if (cpu_reset_req) rst_seen <= rst_seen + 1;
        end
    end
endmodule

// File: testbench.sv
module testbench
    import wdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic bit_tick = 1'b0;
    logic irq_ack, irq_flag, cpu_reset_req;
    logic [7:0] bus_rdata;
    wdc_req_t bus_req = '0;
    int irq_seen, rst_seen, fail_count = 0, checks_done = 0, ei = 0, er = 0;
    logic [7:0] code;
    always #10 core_clk = ~core_clk;
    wdc_watchdog dut_u (.core_clk(core_clk), .rstn(rstn), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .bit_tick(bit_tick), .irq_ack(irq_ack),
        .irq_flag(irq_flag), .cpu_reset_req(cpu_reset_req));
    wdc_cpu_model cpu_u (.core_clk(core_clk), .rstn(rstn), .irq_flag(irq_flag),
        .cpu_reset_req(cpu_reset_req), .irq_ack(irq_ack), .irq_seen(irq_seen),
        .rst_seen(rst_seen));
    // ----------------------------------------
    // bus and check tasks
    // ----------------------------------------
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        checks_done++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge core_clk) bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk) bus_req.wr <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge core_clk) bus_req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk) bus_req.rd <= 1'b0;
        #1 chk("rdata", bus_rdata, e);
    endtask
    // the tick is a one cycle pulse, as the interval timer gives it
    task automatic tick(int n);
        repeat (n) begin
            @(posedge core_clk) bit_tick <= 1'b1;
            @(posedge core_clk) bit_tick <= 1'b0;
        end
        repeat (3) @(posedge core_clk);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        #200000;
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rstn <= 1'b1;
        rd(WDC_ADDR_COMPARE_CLEAR, 8'h7f);
        rd(WDC_ADDR_DISABLE_CODE, 8'h00);
        rd(WDC_ADDR_CONTROL, 8'h10);
        rd(8'h00, 8'h00);
        repeat (300) @(posedge core_clk);
        chk("idle", 8'(irq_seen + rst_seen), 8'h00);
        // modes: plain timer, armed watchdog, watchdog with reset blocked
        for (int m = 0; m < 3; m++) begin
            code = (m == 2) ? 8'ha5 : 8'h00;
            wr(WDC_ADDR_CONTROL, (m == 0) ? 8'h00 : 8'h10);
            wr(WDC_ADDR_DISABLE_CODE, code);
            wr(WDC_ADDR_COMPARE_CLEAR, 8'h83);
            rd(WDC_ADDR_COMPARE_CLEAR, 8'h03);
            rd(WDC_ADDR_DISABLE_CODE, code);
            tick(3);
            chk("early", 8'(irq_seen + rst_seen), 8'(ei + er));
            tick(1);
            if (m == 1) er++;
            else ei++;
            chk("irq", 8'(irq_seen), 8'(ei));
            chk("rst", 8'(rst_seen), 8'(er));
        end
        // armed watchdog kept alive by clearing before the match
        wr(WDC_ADDR_DISABLE_CODE, 8'h00);
        wr(WDC_ADDR_COMPARE_CLEAR, 8'h83);
        tick(2);
        wr(WDC_ADDR_COMPARE_CLEAR, 8'h83);
        tick(2);
        chk("kept", 8'(rst_seen), 8'(er));
        chk("rdidle", bus_rdata, 8'h00);
        give_verdict();
    end
endmodule
